// >>> tbr_pkg.sv
// Constants, register map and carrier types for the time base and clock block
//------------------------------------------------------------------------------
// Overview of operation
// - Tick source bit: 0 picks sub-oscillator, 1 picks main oscillator over 128; resets 0.
// - Tick source bit takes only the first write after reset.
// - Display divide bit: 0 gives time base over 64, 1 over 128; resets 0.
// - Rate code 00..11 divides tick by 128, 4096, 8192, 16384; also watchdog period.
// - Rate field resets to 11, the slowest rate.
// - Watchdog arm bit set enables watchdog reset; every reset clears it.
// - Watchdog arm bit takes only one write after reset.
// - Seconds, minutes, hours counters from sub-oscillator; software can start or stop them.
// - Hours and minutes written to holding first; seconds write loads all three.
// - Seconds read copies hours and minutes into holding for coherent reads.
// - Alarm flag sets when alarm time equals running time.
// - Daily flag sets once a day, seconds flag once a second.
// - Flags stay set until software writes 1; writing 0 does nothing.
// - Enables: daily bit 0, alarm bit 1, seconds bit 2; upper bits read 0; reset 0.
// - Flags set on their event regardless of enable bits.
// - Flags: daily bit 0, alarm bit 1, seconds bit 2.
// - A clock interrupt can wake the device from stop mode.
// - Time base is a 14-bit up-counter feeding display, periodic and watchdog taps.
//------------------------------------------------------------------------------
package tbr_pkg;

	// Time base structure
	localparam int unsigned TB_WIDTH      = 14;
	localparam int unsigned MAIN_PRESCALE = 128;
	localparam int unsigned SUB_OSC_HZ    = 76800;

	// Register offsets
	localparam logic [7:0] ADDR_TBC1      = 8'h30;
	localparam logic [7:0] ADDR_TBC2      = 8'h31;
	localparam logic [7:0] ADDR_RTC_CTRL  = 8'h32;
	localparam logic [7:0] ADDR_SECONDS   = 8'h33;
	localparam logic [7:0] ADDR_MINUTES   = 8'h34;
	localparam logic [7:0] ADDR_HOURS     = 8'h35;
	localparam logic [7:0] ADDR_ALM_SEC   = 8'h36;
	localparam logic [7:0] ADDR_ALM_MIN   = 8'h37;
	localparam logic [7:0] ADDR_ALM_HOUR  = 8'h38;
	localparam logic [7:0] ADDR_FLAGS     = 8'h39;
	localparam logic [7:0] ADDR_ENABLES   = 8'h3a;

	// Field positions
	localparam int unsigned TBC1_TICK_SRC = 0;
	localparam int unsigned TBC1_DISP_DIV = 1;
	localparam int unsigned TBC2_RATE_LO  = 0;
	localparam int unsigned TBC2_RATE_HI  = 1;
	localparam int unsigned TBC2_WDOG_ARM = 7;
	localparam int unsigned CTRL_RUN      = 0;
	localparam int unsigned EVT_DAILY     = 0;
	localparam int unsigned EVT_ALARM     = 1;
	localparam int unsigned EVT_SECONDS   = 2;

	// Reset values
	localparam logic [1:0] RATE_RESET     = 2'h3;
	localparam logic [2:0] EVT_RESET      = 3'h0;

	// Tap exponents (divide by two to the power)
	localparam logic [3:0] DISP_EXP_LO    = 4'h6;
	localparam logic [3:0] DISP_EXP_HI    = 4'h7;
	localparam logic [3:0] RATE_EXP_0     = 4'h7;
	localparam logic [3:0] RATE_EXP_1     = 4'hc;
	localparam logic [3:0] RATE_EXP_2     = 4'hd;
	localparam logic [3:0] RATE_EXP_3     = 4'he;

	// Rollover limits
	localparam logic [5:0] SEC_MAX        = 6'h3b;
	localparam logic [5:0] MIN_MAX        = 6'h3b;
	localparam logic [4:0] HOUR_MAX       = 5'h17;

	// Time of day carrier
	typedef struct packed {
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
	} tbr_time_t;

endpackage : tbr_pkg

// >>> tbr_time_base.sv
// Time base: source select, main oscillator prescaler and 14-bit up-counter
`timescale 1ns/1ps
module tbr_time_base #(
	parameter int unsigned WIDTH    = tbr_pkg::TB_WIDTH,
	parameter int unsigned PRESCALE = tbr_pkg::MAIN_PRESCALE
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Oscillator ticks
	input  wire logic             sub_osc_tick,
	input  wire logic             main_osc_tick,
	input  wire logic             tick_source_select,
	// Counter state
	output logic [WIDTH-1:0]      count,
	output logic                  step
);
	import tbr_pkg::*;

	localparam int unsigned PW = $clog2(PRESCALE);
	localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

	logic [PW-1:0] pre_q;
	logic          pre_hit;
	logic          src_tick;

	// Main oscillator divided down before use
	assign pre_hit  = main_osc_tick && (pre_q == PRE_LAST);
	assign src_tick = tick_source_select ? pre_hit : sub_osc_tick;

	// Prescaler
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			pre_q <= '0;
		else if (main_osc_tick)
			pre_q <= pre_hit ? '0 : pre_q + 1'b1;
	end

	// Up-counter; step marks the cycle after each advance
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count <= '0;
			step  <= 1'b0;
		end else begin
			step <= src_tick;
			if (src_tick)
				count <= count + 1'b1;
		end
	end

endmodule : tbr_time_base

// >>> tbr_rtc_count.sv
// Real-time clock: one-second prescaler and cascaded second, minute, hour counters
`timescale 1ns/1ps
module tbr_rtc_count #(
	parameter int unsigned SUB_TICKS = tbr_pkg::SUB_OSC_HZ
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       sub_osc_tick,
	input  wire logic       run,
	input  wire logic       load,
	input  tbr_pkg::tbr_time_t load_time,
	// State and events
	output tbr_pkg::tbr_time_t now,
	output logic            sec_pulse,
	output logic            day_pulse
);
	import tbr_pkg::*;

	localparam int unsigned PW = $clog2(SUB_TICKS);
	localparam logic [PW-1:0] PRE_LAST = PW'(SUB_TICKS - 1);

	logic [PW-1:0] pre_q;
	logic          adv;
	logic          sec_wrap;
	logic          min_wrap;
	logic          hour_wrap;

	assign adv       = run && sub_osc_tick && (pre_q == PRE_LAST);
	assign sec_wrap  = now.seconds == SEC_MAX;
	assign min_wrap  = sec_wrap && (now.minutes == MIN_MAX);
	assign hour_wrap = min_wrap && (now.hours == HOUR_MAX);

	// One-second prescaler, restarted by a time load
	always_ff @(posedge sys_clk) begin
		if (!rst_n || load)
			pre_q <= '0;
		else if (run && sub_osc_tick)
			pre_q <= adv ? '0 : pre_q + 1'b1;
	end

	// Cascaded counters with simultaneous load
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			now <= '0;
		end else if (load) begin
			now <= load_time;
		end else if (adv) begin
			now.seconds <= sec_wrap ? '0 : now.seconds + 1'b1;
			if (sec_wrap)
				now.minutes <= min_wrap ? '0 : now.minutes + 1'b1;
			if (min_wrap)
				now.hours <= hour_wrap ? '0 : now.hours + 1'b1;
		end
	end

	// Event pulses
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sec_pulse <= 1'b0;
			day_pulse <= 1'b0;
		end else begin
			sec_pulse <= adv && !load;
			day_pulse <= adv && !load && hour_wrap;
		end
	end

endmodule : tbr_rtc_count

// >>> tbr_top.sv
// Time base control, watchdog, real-time clock registers and event flags
`timescale 1ns/1ps
module tbr_top #(
	parameter int unsigned SUB_TICKS_PER_SEC = tbr_pkg::SUB_OSC_HZ
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wr_data,
	input  wire logic       reg_wr_en,
	input  wire logic       reg_rd_en,
	output logic [7:0]      reg_rd_data,
	// Oscillator ticks
	input  wire logic       sub_osc_tick,
	input  wire logic       main_osc_tick,
	// Watchdog service
	input  wire logic       watchdog_clear,
	output logic            watchdog_reset,
	// Time base taps
	output logic            display_clk_en,
	output logic            periodic_interrupt,
	// Clock interrupt
	output logic            clock_irq,
	output logic            stop_wake
);
	import tbr_pkg::*;

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------

	// True when the low exp bits of the counter are all zero
	function automatic logic div_hit(
		input logic [TB_WIDTH-1:0] cnt,
		input logic [3:0]          exp
	);
		logic [TB_WIDTH-1:0] mask;
		mask = '0;
		for (int i = 0; i < TB_WIDTH; i++)
			mask[i] = (i < int'(exp));
		return (cnt & mask) == '0;
	endfunction : div_hit

	// Exponent for each rate code
	function automatic logic [3:0] rate_exp(input logic [1:0] code);
		logic [3:0] e;
		e = RATE_EXP_3;
		unique case (code)
			2'h0: e = RATE_EXP_0;
			2'h1: e = RATE_EXP_1;
			2'h2: e = RATE_EXP_2;
			2'h3: e = RATE_EXP_3;
		endcase
		return e;
	endfunction : rate_exp

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------

	logic                tick_src_q;
	logic                tick_src_lock_q;
	logic                disp_div_q;
	logic [1:0]          rate_q;
	logic                wdog_arm_q;
	logic                wdog_lock_q;
	logic                run_q;
	logic [4:0]          hold_hours_q;
	logic [5:0]          hold_min_q;
	tbr_time_t           alarm_q;
	logic [2:0]          flags_q;
	logic [2:0]          flags_d;
	logic [2:0]          enables_q;
	logic [7:0]          rd_data_q;
	logic                wdog_stage_q;
	logic                wdog_reset_q;
	logic                disp_q;
	logic                periodic_q;
	logic                match_q;
	logic                match;
	logic [2:0]          events;
	logic [TB_WIDTH-1:0] tb_count;
	logic                tb_step;
	logic                rate_tick;
	tbr_time_t           now;
	tbr_time_t           load_time;
	logic                load;
	logic                sec_pulse;
	logic                day_pulse;

	// Decoded strobes
	logic wr_tbc1;
	logic wr_tbc2;
	logic wr_secs;
	logic rd_secs;
	logic wr_flags;

	assign wr_tbc1  = reg_wr_en && (reg_addr == ADDR_TBC1);
	assign wr_tbc2  = reg_wr_en && (reg_addr == ADDR_TBC2);
	assign wr_secs  = reg_wr_en && (reg_addr == ADDR_SECONDS);
	assign rd_secs  = reg_rd_en && (reg_addr == ADDR_SECONDS);
	assign wr_flags = reg_wr_en && (reg_addr == ADDR_FLAGS);

	//------------------------------------------------------------------
	// Time base control one
	//------------------------------------------------------------------

	// Tick source accepts the first write only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_src_q      <= 1'b0;
			tick_src_lock_q <= 1'b0;
		end else if (wr_tbc1 && !tick_src_lock_q) begin
			tick_src_q      <= reg_wr_data[TBC1_TICK_SRC];
			tick_src_lock_q <= 1'b1;
		end
	end

	// Display divide select
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			disp_div_q <= 1'b0;
		else if (wr_tbc1)
			disp_div_q <= reg_wr_data[TBC1_DISP_DIV];
	end

	//------------------------------------------------------------------
	// Time base control two
	//------------------------------------------------------------------

	// Periodic rate field
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			rate_q <= RATE_RESET;
		else if (wr_tbc2)
			rate_q <= {reg_wr_data[TBC2_RATE_HI], reg_wr_data[TBC2_RATE_LO]};
	end

	// Watchdog arm accepts one write only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wdog_arm_q  <= 1'b0;
			wdog_lock_q <= 1'b0;
		end else if (wr_tbc2 && !wdog_lock_q) begin
			wdog_arm_q  <= reg_wr_data[TBC2_WDOG_ARM];
			wdog_lock_q <= 1'b1;
		end
	end

	//------------------------------------------------------------------
	// Time base and taps
	//------------------------------------------------------------------

	tbr_time_base #(
		.WIDTH              (TB_WIDTH),
		.PRESCALE           (MAIN_PRESCALE)
	) u_time_base (
		.sys_clk            (sys_clk),
		.rst_n              (rst_n),
		.sub_osc_tick       (sub_osc_tick),
		.main_osc_tick      (main_osc_tick),
		.tick_source_select (tick_src_q),
		.count              (tb_count),
		.step               (tb_step)
	);

	// Rate tap shared by periodic interrupt and watchdog
	assign rate_tick = tb_step && div_hit(tb_count, rate_exp(rate_q));

	// Registered tap pulses
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			disp_q     <= 1'b0;
			periodic_q <= 1'b0;
		end else begin
			disp_q     <= tb_step && div_hit(tb_count,
				disp_div_q ? DISP_EXP_HI : DISP_EXP_LO);
			periodic_q <= rate_tick;
		end
	end

	assign display_clk_en     = disp_q;
	assign periodic_interrupt = periodic_q;

	//------------------------------------------------------------------
	// Watchdog
	//------------------------------------------------------------------

	// Two rate ticks without service while armed cause a time-out
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wdog_stage_q <= 1'b0;
			wdog_reset_q <= 1'b0;
		end else begin
			wdog_reset_q <= 1'b0;
			if (watchdog_clear)
				wdog_stage_q <= 1'b0;
			else if (rate_tick) begin
				wdog_stage_q <= 1'b1;
				if (wdog_stage_q && wdog_arm_q)
					wdog_reset_q <= 1'b1;
			end
		end
	end

	assign watchdog_reset = wdog_reset_q;

	//------------------------------------------------------------------
	// Real-time clock
	//------------------------------------------------------------------

	// Run control
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			run_q <= 1'b0;
		else if (reg_wr_en && (reg_addr == ADDR_RTC_CTRL))
			run_q <= reg_wr_data[CTRL_RUN];
	end

	// Seconds write loads holding values with the new seconds
	assign load      = wr_secs;
	assign load_time = '{hours:   hold_hours_q,
	                     minutes: hold_min_q,
	                     seconds: reg_wr_data[5:0]};

	tbr_rtc_count #(
		.SUB_TICKS    (SUB_TICKS_PER_SEC)
	) u_rtc (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.sub_osc_tick (sub_osc_tick),
		.run          (run_q),
		.load         (load),
		.load_time    (load_time),
		.now          (now),
		.sec_pulse    (sec_pulse),
		.day_pulse    (day_pulse)
	);

	// Holding registers: software writes, snapshot on seconds read
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			hold_hours_q <= '0;
			hold_min_q   <= '0;
		end else if (rd_secs) begin
			hold_hours_q <= now.hours;
			hold_min_q   <= now.minutes;
		end else if (reg_wr_en) begin
			if (reg_addr == ADDR_HOURS)
				hold_hours_q <= reg_wr_data[4:0];
			if (reg_addr == ADDR_MINUTES)
				hold_min_q <= reg_wr_data[5:0];
		end
	end

	// Alarm compare registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			alarm_q <= '0;
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				ADDR_ALM_SEC:  alarm_q.seconds <= reg_wr_data[5:0];
				ADDR_ALM_MIN:  alarm_q.minutes <= reg_wr_data[5:0];
				ADDR_ALM_HOUR: alarm_q.hours   <= reg_wr_data[4:0];
				default: ;
			endcase
		end
	end

	// Alarm match, taken on its first cycle only
	assign match = (alarm_q == now);

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			match_q <= 1'b1; // Time and alarm both clear: no false edge
		else
			match_q <= match;
	end

	//------------------------------------------------------------------
	// Event flags and enables
	//------------------------------------------------------------------

	// Events raise flags whatever the enables say
	always_comb begin
		events              = '0;
		events[EVT_DAILY]   = day_pulse;
		events[EVT_ALARM]   = match && !match_q;
		events[EVT_SECONDS] = sec_pulse;
	end

	// Write one clears; a same-cycle event wins
	always_comb begin
		flags_d = flags_q;
		if (wr_flags)
			flags_d = flags_q & ~reg_wr_data[2:0];
		flags_d = flags_d | events;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			flags_q <= EVT_RESET;
		else
			flags_q <= flags_d;
	end

	// Interrupt enables
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			enables_q <= EVT_RESET;
		else if (reg_wr_en && (reg_addr == ADDR_ENABLES))
			enables_q <= reg_wr_data[2:0];
	end

	// Shared request, also the stop-mode wake
	assign clock_irq = |(flags_q & enables_q);
	assign stop_wake = clock_irq;

	//------------------------------------------------------------------
	// Read data
	//------------------------------------------------------------------

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= 8'h00;
			if (reg_rd_en) begin
				unique case (reg_addr)
					ADDR_TBC1:     rd_data_q <= {6'h00, disp_div_q, tick_src_q};
					ADDR_TBC2:     rd_data_q <= {wdog_arm_q, 5'h00, rate_q};
					ADDR_RTC_CTRL: rd_data_q <= {7'h00, run_q};
					ADDR_SECONDS:  rd_data_q <= {2'h0, now.seconds};
					ADDR_MINUTES:  rd_data_q <= {2'h0, hold_min_q};
					ADDR_HOURS:    rd_data_q <= {3'h0, hold_hours_q};
					ADDR_ALM_SEC:  rd_data_q <= {2'h0, alarm_q.seconds};
					ADDR_ALM_MIN:  rd_data_q <= {2'h0, alarm_q.minutes};
					ADDR_ALM_HOUR: rd_data_q <= {3'h0, alarm_q.hours};
					ADDR_FLAGS:    rd_data_q <= {5'h00, flags_q};
					ADDR_ENABLES:  rd_data_q <= {5'h00, enables_q};
					default:       rd_data_q <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rd_data = rd_data_q;

endmodule : tbr_top

// >>> tbr_properties.sv
// Port checker for the time base and clock block
`timescale 1ns/1ps
module tbr_properties #(
	parameter int unsigned SUB_TICKS_PER_SEC = tbr_pkg::SUB_OSC_HZ
) (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic       reg_wr_en,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	// Ticks, watchdog and taps
	input wire logic       sub_osc_tick,
	input wire logic       main_osc_tick,
	input wire logic       watchdog_clear,
	input wire logic       watchdog_reset,
	input wire logic       display_clk_en,
	input wire logic       periodic_interrupt,
	input wire logic       clock_irq,
	input wire logic       stop_wake
);
	import tbr_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic [2:0] en_q;
	logic       src_q;
	logic       src_lock_q;
	logic       arm_q;
	logic       arm_lock_q;
	// Shadow of the event enables
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			en_q <= 3'h0;
		end else if (reg_wr_en && reg_addr == ADDR_ENABLES) begin
			en_q <= reg_wr_data[2:0];
		end
	end
	// Shadow of the write-once bits, locked by the first write
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			{src_q, src_lock_q, arm_q, arm_lock_q} <= 4'h0;
		end else if (reg_wr_en) begin
			if (reg_addr == ADDR_TBC1 && !src_lock_q) begin
				src_q      <= reg_wr_data[TBC1_TICK_SRC];
				src_lock_q <= 1'b1;
			end
			if (reg_addr == ADDR_TBC2 && !arm_lock_q) begin
				arm_q      <= reg_wr_data[TBC2_WDOG_ARM];
				arm_lock_q <= 1'b1;
			end
		end
	end
	a_read_idle_zero: assert property (!$past(reg_rd_en) |-> reg_rd_data == 8'h00)
		else $error("read data not zero outside the answer cycle");
	a_enables_readback: assert property (reg_rd_en && reg_addr == ADDR_ENABLES |=> reg_rd_data == {5'h00, en_q})
		else $error("enables read back wrong");
	a_flags_upper_zero: assert property (reg_rd_en && reg_addr == ADDR_FLAGS |=> reg_rd_data[7:3] == 5'h00)
		else $error("flag register upper bits not zero");
	a_unmapped_reads_zero: assert property (reg_rd_en && (reg_addr < ADDR_TBC1 || reg_addr > ADDR_ENABLES)
		|=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
	a_tick_src_once: assert property (reg_rd_en && reg_addr == ADDR_TBC1 |=> reg_rd_data[0] == src_q)
		else $error("tick source bit took a later write");
	a_arm_once: assert property (reg_rd_en && reg_addr == ADDR_TBC2 |=> reg_rd_data[7] == arm_q)
		else $error("watchdog arm bit took a later write");
	a_wdog_needs_arm: assert property (watchdog_reset |-> $past(arm_q))
		else $error("watchdog reset while not armed");
	a_irq_needs_enable: assert property (en_q == 3'h0 |-> !clock_irq)
		else $error("clock interrupt with all enables clear");
	a_wake_follows_irq: assert property (stop_wake == clock_irq)
		else $error("stop wake differs from clock interrupt");
	a_periodic_single: assert property (periodic_interrupt |=> !periodic_interrupt [*8])
		else $error("periodic pulses too close");
	a_display_single: assert property ($rose(display_clk_en) |=> !display_clk_en [*8])
		else $error("display pulses too close");
endmodule : tbr_properties

bind tbr_top tbr_properties #(.SUB_TICKS_PER_SEC(SUB_TICKS_PER_SEC)) u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
	.sub_osc_tick(sub_osc_tick), .main_osc_tick(main_osc_tick), .watchdog_clear(watchdog_clear),
	.watchdog_reset(watchdog_reset), .display_clk_en(display_clk_en),
	.periodic_interrupt(periodic_interrupt), .clock_irq(clock_irq), .stop_wake(stop_wake));

// >>> tbr_cpu_model.sv
// Register bus master standing in for the CPU core
`timescale 1ns/1ps
module tbr_cpu_model (
	// Clock
	input  wire logic       sys_clk,
	// Register port
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wr_data,
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	input  wire logic [7:0] reg_rd_data
);
	import tbr_pkg::*;
	// Idle bus at time zero
	initial begin
		reg_addr    = 8'h00;
		reg_wr_data = 8'h00;
		reg_wr_en   = 1'b0;
		reg_rd_en   = 1'b0;
	end
	// One-cycle write; released lines show inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr    <= a;
		reg_wr_data <= v;
		reg_wr_en   <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en   <= 1'b0;
		reg_addr    <= ~a;
		reg_wr_data <= ~v;
	endtask : wr
	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		reg_addr  <= ~a;
		@(negedge sys_clk);
		v = reg_rd_data;
	endtask : rd
	// Hours and minutes first, seconds last to load
	task automatic set_time(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
		wr(ADDR_HOURS, {3'h0, h});
		wr(ADDR_MINUTES, {2'h0, m});
		wr(ADDR_SECONDS, {2'h0, s});
	endtask : set_time
	// Seconds first so hours and minutes come from the snapshot
	task automatic get_time(output tbr_time_t t);
		logic [7:0] s;
		logic [7:0] m;
		logic [7:0] h;
		rd(ADDR_SECONDS, s);
		rd(ADDR_HOURS, h);
		rd(ADDR_MINUTES, m);
		t = {h[4:0], m[5:0], s[5:0]};
	endtask : get_time
	// Service routine clears each handled flag
	task automatic clear_flags(input logic [7:0] f);
		wr(ADDR_FLAGS, f);
	endtask : clear_flags
endmodule : tbr_cpu_model

// >>> tbr_top_tb_top.sv
// Self-checking testbench for the time base and clock block
`timescale 1ns/1ps
module tbr_top_tb_top;
	import tbr_pkg::*;
	logic       sys_clk;
	logic       rst_n;
	logic       sub_on;
	logic       sub_osc_tick;
	logic       main_osc_tick;
	logic       watchdog_clear;
	logic [7:0] reg_addr;
	logic [7:0] reg_wr_data;
	logic       reg_wr_en;
	logic       reg_rd_en;
	logic [7:0] reg_rd_data;
	logic       watchdog_reset;
	logic       display_clk_en;
	logic       periodic_interrupt;
	logic       clock_irq;
	logic       stop_wake;
	int         mismatches;
	int         tests_run;
	int         wd_hits;
	tbr_time_t  t;
	// Clock, oscillator ticks and watchdog pulse count
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		sub_osc_tick  <= sub_on;
		main_osc_tick <= sub_on;
	end
	always @(negedge sys_clk) begin
		if (watchdog_reset === 1'b1) begin
			wd_hits++;
		end
	end
	tbr_top #(.SUB_TICKS_PER_SEC(4)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
		.sub_osc_tick(sub_osc_tick), .main_osc_tick(main_osc_tick), .watchdog_clear(watchdog_clear),
		.watchdog_reset(watchdog_reset), .display_clk_en(display_clk_en),
		.periodic_interrupt(periodic_interrupt), .clock_irq(clock_irq), .stop_wake(stop_wake));
	tbr_cpu_model i_cpu (
		.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));
	//----------------------------------------
	// Checking and control tasks
	//----------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task automatic rd_chk(string name, logic [7:0] a, logic [7:0] m, logic [7:0] e);
		logic [7:0] v;
		i_cpu.rd(a, v);
		chk(name, v & m, e);
	endtask : rd_chk
	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask : do_reset
	// Bounded wait for a pulse: 0 periodic, 1 display, 2 watchdog
	task automatic wait_ev(int sel, int lim, output int cnt);
		logic hit;
		cnt = 0;
		do begin
			@(negedge sys_clk);
			cnt++;
			hit = (sel == 0) ? periodic_interrupt : (sel == 1) ? display_clk_en : watchdog_reset;
		end while (hit !== 1'b1 && cnt < lim);
		if (hit !== 1'b1) begin
			mismatches++;
			$display("wrong value pulse %0d expected 1 seen 0", sel);
			give_verdict();
		end
	endtask : wait_ev
	task automatic period_chk(string name, int sel, int e);
		int n;
		wait_ev(sel, 20000, n);
		wait_ev(sel, 20000, n);
		chk(name, n, e);
	endtask : period_chk
	//----------------------------------------
	// Scenarios
	//----------------------------------------
	task automatic sc_reset_values();
		rd_chk("enables", ADDR_ENABLES, 8'hff, 8'h00);
		rd_chk("flags", ADDR_FLAGS, 8'hff, 8'h00);
		rd_chk("tbc1", ADDR_TBC1, 8'h03, 8'h00);
		rd_chk("tbc2", ADDR_TBC2, 8'h83, {6'h00, RATE_RESET});
		rd_chk("unmapped", 8'h3b, 8'hff, 8'h00);
		i_cpu.wr(ADDR_ENABLES, 8'hff);
		rd_chk("enables wr", ADDR_ENABLES, 8'hff, 8'h07);
	endtask : sc_reset_values
	task automatic sc_write_once();
		i_cpu.wr(ADDR_TBC1, 8'h03);
		i_cpu.wr(ADDR_TBC1, 8'h00);
		rd_chk("tick once", ADDR_TBC1, 8'h03, 8'h01);
		i_cpu.wr(ADDR_TBC2, 8'h80);
		i_cpu.wr(ADDR_TBC2, 8'h02);
		rd_chk("arm once", ADDR_TBC2, 8'h83, 8'h82);
		do_reset();
		rd_chk("arm cleared", ADDR_TBC2, 8'h80, 8'h00);
		i_cpu.wr(ADDR_TBC1, 8'h01);
		rd_chk("tick relock", ADDR_TBC1, 8'h01, 8'h01);
		period_chk("main display", 1, 64 * 128);
	endtask : sc_write_once
	task automatic sc_rates();
		i_cpu.wr(ADDR_TBC1, 8'h00);
		for (int c = 0; c < 4; c++) begin
			i_cpu.wr(ADDR_TBC2, 8'(c));
			period_chk("rate period", 0, 1 << ((c == 0) ? 7 : 11 + c));
		end
		for (int c = 0; c < 2; c++) begin
			i_cpu.wr(ADDR_TBC1, 8'(c << 1));
			period_chk("display period", 1, 64 << c);
		end
	endtask : sc_rates
	task automatic sc_watchdog();
		int n;
		wd_hits = 0;
		i_cpu.wr(ADDR_TBC2, 8'h80);
		repeat (6) begin
			repeat (100) @(posedge sys_clk);
			watchdog_clear <= 1'b1;
			@(posedge sys_clk);
			watchdog_clear <= 1'b0;
		end
		chk("serviced", wd_hits, 0);
		wait_ev(2, 300, n);
		do_reset();
		rd_chk("arm after timeout", ADDR_TBC2, 8'h80, 8'h00);
	endtask : sc_watchdog
	task automatic sc_rtc();
		sub_on <= 1'b0;
		i_cpu.wr(ADDR_ALM_HOUR, 8'h00);
		i_cpu.wr(ADDR_ALM_MIN, 8'h00);
		i_cpu.wr(ADDR_ALM_SEC, 8'h01);
		i_cpu.set_time(5'd23, 6'd59, 6'd58);
		i_cpu.wr(ADDR_RTC_CTRL, 8'h01);
		sub_on <= 1'b1;
		repeat (14) @(posedge sys_clk);
		sub_on <= 1'b0;
		repeat (4) @(posedge sys_clk);
		i_cpu.get_time(t);
		chk("rollover", t, {5'd0, 6'd0, 6'd1});
		rd_chk("events", ADDR_FLAGS, 8'hff, 8'h07);
		chk("irq masked", clock_irq, 1'b0);
		i_cpu.wr(ADDR_ENABLES, 8'h02);
		@(negedge sys_clk);
		chk("irq alarm", clock_irq, 1'b1);
		i_cpu.wr(ADDR_FLAGS, 8'h00);
		rd_chk("write zero", ADDR_FLAGS, 8'hff, 8'h07);
		i_cpu.clear_flags(8'h02);
		rd_chk("alarm cleared", ADDR_FLAGS, 8'hff, 8'h05);
		chk("irq off", clock_irq, 1'b0);
		i_cpu.clear_flags(8'h05);
		rd_chk("all cleared", ADDR_FLAGS, 8'hff, 8'h00);
		i_cpu.set_time(5'd0, 6'd5, 6'd59);
		sub_on <= 1'b1;
		rd_chk("seconds", ADDR_SECONDS, 8'hff, 8'h3b);
		repeat (8) @(posedge sys_clk);
		rd_chk("snapshot", ADDR_MINUTES, 8'hff, 8'h05);
		i_cpu.get_time(t);
		chk("minute carry", t.minutes, 6'h06);
		sub_on <= 1'b0;
	endtask : sc_rtc
	// Main sequence
	initial begin
		sys_clk        = 1'b0;
		rst_n          = 1'b0;
		sub_on         = 1'b1;
		sub_osc_tick   = 1'b0;
		main_osc_tick  = 1'b0;
		watchdog_clear = 1'b0;
		mismatches     = 0;
		tests_run      = 0;
		wd_hits        = 0;
		do_reset();
		sc_reset_values();
		do_reset();
		sc_write_once();
		do_reset();
		sc_rates();
		do_reset();
		sc_watchdog();
		do_reset();
		sc_rtc();
		give_verdict();
	end
endmodule : tbr_top_tb_top
